// ===== shared/adr_pkg.sv
`default_nettype none
package adr_pkg;
  localparam int          ADR_DATA_W        = 32;
  localparam int          ADR_RES_W         = 10;
  localparam int          ADR_NORM_CNT      = 12;
  localparam int          ADR_SLOT_CNT      = 13;
  localparam int          ADR_PRIO_SLOT     = 12;

  // Register byte offsets
  localparam logic [7:0]  ADR_OFS_RESULT0   = 8'h00;
  localparam logic [7:0]  ADR_OFS_PRIO      = 8'h30;
  localparam logic [7:0]  ADR_OFS_THR0      = 8'h34;
  localparam logic [7:0]  ADR_OFS_THR1      = 8'h38;
  localparam logic [7:0]  ADR_OFS_MON0_CFG  = 8'h3c;
  localparam logic [7:0]  ADR_OFS_MON1_CFG  = 8'h40;
  localparam logic [7:0]  ADR_OFS_IRQ_STAT  = 8'h44;
  localparam logic [7:0]  ADR_OFS_IRQ_MASK  = 8'h48;

  // Result and threshold field positions
  localparam int          ADR_VAL_LSB       = 6;
  localparam int          ADR_VAL_MSB       = 15;
  localparam int          ADR_OVR_BIT       = 1;
  localparam int          ADR_RF_BIT        = 0;

  // Monitor configuration field positions
  localparam int          ADR_MON_EN_BIT    = 0;
  localparam int          ADR_MON_SEL_LSB   = 1;
  localparam int          ADR_MON_SEL_MSB   = 4;
  localparam int          ADR_MON_DIR_BIT   = 5;
  localparam int          ADR_MON_CFG_W     = 6;

  // Reset values
  localparam logic [9:0]  ADR_RST_VAL       = 10'h000;
  localparam logic [9:0]  ADR_RST_THR       = 10'h000;
  localparam logic [5:0]  ADR_RST_MON_CFG   = 6'h00;
  localparam logic [1:0]  ADR_RST_IRQ       = 2'h0;
  localparam logic [31:0] ADR_RST_PRDATA    = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== hw/adr_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module adr_monitor
  import adr_pkg::*;
#(
  parameter int RES_W = ADR_RES_W
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Configuration
  input  wire logic             enable,
  input  wire logic             direction,
  input  wire logic [RES_W-1:0] threshold,
  // Store watched
  input  wire logic             store,
  input  wire logic [RES_W-1:0] value,
  // Hit pulse
  output logic                  hit
);
  logic below;
  logic above;
  logic hit_nxt;
  logic hit_r;

  // Compare the incoming value so the hit is never a stale result
  assign below   = value < threshold;
  assign above   = value > threshold;
  assign hit_nxt = enable & store & (direction ? above : below);
  assign hit     = hit_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_r <= 1'b0;
    end else if (ce) begin
      hit_r <= hit_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== hw/adr_regs.sv
// Summary of operation
// - Twelve read-only normal result words, indexed zero to eleven, are provided.
// - A normal result word shows its 10-bit value in bits 15..6 with 31..16 and 5..2 zero.
// - Bit 1 of a normal result flags an overrun when an unread value is replaced, cleared on read.
// - Bit 0 of each result word is set whenever a new value is stored there.
// - Reading a result word clears its stored flag.
// - A separate top-priority result word holds its value in 15..6 and its own stored flag in bit 0.
// - The top-priority word flags its own overrun in bit 1, cleared on read.
// - Threshold zero is a writable 10-bit field in 15..6, other bits zero, reset zero.
// - Threshold one is a writable 10-bit field in 15..6 used by monitor one, other bits zero.
// - Each monitor compares its chosen result on every store and raises its interrupt on a hit.
// - Target codes 0000..0111 pick normal results 0..7 and any code with bit 3 set picks priority.
// - Direction zero hits below the threshold, one hits above, and an enable bit turns it on.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module adr_regs
  import adr_pkg::*;
#(
  parameter int RES_W    = ADR_RES_W,
  parameter int NORM_CNT = ADR_NORM_CNT
) (
  // Clock, reset, enable
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Converter result stores
  input  wire logic             norm_store,
  input  wire logic [3:0]       norm_index,
  input  wire logic [RES_W-1:0] norm_value,
  input  wire logic             prio_store,
  input  wire logic [RES_W-1:0] prio_value,
  // Interrupts
  output logic                  monitor0_irq,
  output logic                  monitor1_irq,
  output logic                  irq
);
  localparam int SLOTS = NORM_CNT + 1;
  localparam int PRIO  = NORM_CNT;

  // Monitor target decode, shared by both channels
  function automatic logic [3:0] target_slot(input logic [3:0] code);
    target_slot = code[3] ? 4'(PRIO) : {1'b0, code[2:0]};
  endfunction

  logic [RES_W-1:0]         val_r [SLOTS];
  logic [SLOTS-1:0]         rf_r;
  logic [SLOTS-1:0]         ovr_r;
  logic [SLOTS-1:0]         store_vec;
  logic [SLOTS-1:0]         rd_clr;
  logic [RES_W-1:0]         thr_r [2];
  logic [ADR_MON_CFG_W-1:0] cfg_r [2];
  logic [1:0]               stat_r;
  logic [1:0]               stat_nxt;
  logic [1:0]               mask_r;
  logic [1:0]               hit;
  logic [31:0]              prdata_r;
  logic [31:0]              rd_mux;

  // Bus decode
  logic       setup_rd;
  logic       acc_wr;
  logic [5:0] word_idx;
  logic       is_result;
  logic       is_prio;
  logic       is_thr0;
  logic       is_thr1;
  logic       is_cfg0;
  logic       is_cfg1;
  logic       is_stat;
  logic       is_mask;
  logic       mapped;
  logic [3:0] rd_slot;
  logic [31:0] res_word;

  assign setup_rd  = psel & ~penable & ~pwrite;
  assign acc_wr    = psel & penable & pwrite;
  assign word_idx  = paddr[7:2];
  assign is_result = (word_idx < 6'(NORM_CNT)) && (paddr[1:0] == 2'h0);
  assign is_prio   = paddr == ADR_OFS_PRIO;
  assign is_thr0   = paddr == ADR_OFS_THR0;
  assign is_thr1   = paddr == ADR_OFS_THR1;
  assign is_cfg0   = paddr == ADR_OFS_MON0_CFG;
  assign is_cfg1   = paddr == ADR_OFS_MON1_CFG;
  assign is_stat   = paddr == ADR_OFS_IRQ_STAT;
  assign is_mask   = paddr == ADR_OFS_IRQ_MASK;
  assign mapped    = is_result | is_prio | is_thr0 | is_thr1 | is_cfg0 | is_cfg1
                   | is_stat | is_mask;
  assign rd_slot   = is_prio ? 4'(PRIO) : word_idx[3:0];

  // Zero wait states; prdata is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_r;

  // Result word layout, shared by normal and priority words
  assign res_word = {16'h0000, val_r[rd_slot], 4'h0, ovr_r[rd_slot], rf_r[rd_slot]};

  assign rd_mux = (is_result | is_prio) ? res_word :
                  is_thr0 ? {16'h0000, thr_r[0], 6'h00} :
                  is_thr1 ? {16'h0000, thr_r[1], 6'h00} :
                  is_cfg0 ? {26'h0, cfg_r[0]} :
                  is_cfg1 ? {26'h0, cfg_r[1]} :
                  is_stat ? {30'h0, stat_r} :
                  is_mask ? {30'h0, mask_r} : 32'h0000_0000;

  // Store strobes and read clears per slot
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      if (g == PRIO) begin : g_prio
        assign store_vec[g] = prio_store;
      end else begin : g_norm
        assign store_vec[g] = norm_store & (norm_index == 4'(g));
      end
      // Snapshot and clear happen together, so no store slips between them
      assign rd_clr[g] = setup_rd & (is_result | is_prio) & (rd_slot == 4'(g));

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          val_r[g] <= ADR_RST_VAL;
          rf_r[g]  <= 1'b0;
          ovr_r[g] <= 1'b0;
        end else if (ce) begin
          if (store_vec[g]) begin
            val_r[g] <= (g == PRIO) ? prio_value : norm_value;
          end
          rf_r[g]  <= (rf_r[g] & ~rd_clr[g]) | store_vec[g];
          ovr_r[g] <= (ovr_r[g] & ~rd_clr[g])
                    | (store_vec[g] & rf_r[g] & ~rd_clr[g]);
        end
      end
    end
  endgenerate

  // Monitor channels
  generate
    for (g = 0; g < 2; g++) begin : g_mon
      logic [3:0] tgt;
      assign tgt = target_slot(cfg_r[g][ADR_MON_SEL_MSB:ADR_MON_SEL_LSB]);

      adr_monitor #(
        .RES_W     (RES_W)
      ) u_mon (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .enable    (cfg_r[g][ADR_MON_EN_BIT]),
        .direction (cfg_r[g][ADR_MON_DIR_BIT]),
        .threshold (thr_r[g]),
        .store     (store_vec[tgt]),
        .value     ((tgt == 4'(PRIO)) ? prio_value : norm_value),
        .hit       (hit[g])
      );
    end
  endgenerate

  assign monitor0_irq = hit[0];
  assign monitor1_irq = hit[1];

  // Sticky status; a hit beats a write-one clear in the same cycle
  assign stat_nxt = (stat_r & ~((acc_wr & is_stat) ? pwdata[1:0] : 2'h0)) | hit;
  assign irq      = |(stat_r & mask_r);

  // Configuration and thresholds; monitor should be off while rewriting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_r[0] <= ADR_RST_THR;
      thr_r[1] <= ADR_RST_THR;
      cfg_r[0] <= ADR_RST_MON_CFG;
      cfg_r[1] <= ADR_RST_MON_CFG;
      mask_r   <= ADR_RST_IRQ;
      stat_r   <= ADR_RST_IRQ;
    end else if (ce) begin
      if (acc_wr & is_thr0) begin
        thr_r[0] <= pwdata[ADR_VAL_MSB:ADR_VAL_LSB];
      end
      if (acc_wr & is_thr1) begin
        thr_r[1] <= pwdata[ADR_VAL_MSB:ADR_VAL_LSB];
      end
      if (acc_wr & is_cfg0) begin
        cfg_r[0] <= pwdata[ADR_MON_CFG_W-1:0];
      end
      if (acc_wr & is_cfg1) begin
        cfg_r[1] <= pwdata[ADR_MON_CFG_W-1:0];
      end
      if (acc_wr & is_mask) begin
        mask_r <= pwdata[1:0];
      end
      stat_r <= stat_nxt;
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= ADR_RST_PRDATA;
    end else if (ce && setup_rd) begin
      prdata_r <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// ===== sim/adr_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module adr_regs_chk
  import adr_pkg::*;
#(
  parameter int RES_W    = ADR_RES_W,
  parameter int NORM_CNT = ADR_NORM_CNT
) (
  // Clock, reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Stores and interrupts
  input wire logic        norm_store,
  input wire logic        prio_store,
  input wire logic        monitor0_irq,
  input wire logic        monitor1_irq,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_acc;
  wire logic no_st;
  assign rd_acc = psel && penable && !pwrite;
  assign no_st  = ce && !norm_store && !prio_store;
  // Stores anywhere in the pair would legally set the flags again
  sequence rd_res_s;
    psel && !penable && !pwrite && no_st && paddr < ADR_OFS_THR0;
  endsequence
  sequence rd_same_s;
    psel && !penable && !pwrite && no_st && paddr == $past(paddr, 3);
  endsequence
  chk_read_clear: assert property (
    rd_res_s ##1 (rd_acc && no_st) ##1 (!psel && no_st) ##1 rd_same_s |=> prdata[1:0] == 2'b00)
    else $error("result flags survive a read");
  chk_rsvd_zero: assert property (
    rd_acc && paddr < ADR_OFS_THR0 |-> prdata[31:16] == 16'h0 && prdata[5:2] == 4'h0)
    else $error("reserved result bits not zero");
  chk_thr_zero: assert property (
    rd_acc && (paddr == ADR_OFS_THR0 || paddr == ADR_OFS_THR1) |-> prdata[5:0] == 6'h0
    && prdata[31:16] == 16'h0) else $error("reserved threshold bits not zero");
  chk_unmapped_err: assert property (
    rd_acc && paddr > ADR_OFS_IRQ_MASK |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  chk_ready_high: assert property (pready)
    else $error("wait state inserted");
  chk_hit0_cause: assert property (
    monitor0_irq |-> $past(norm_store) || $past(prio_store))
    else $error("monitor zero pulse without store");
  chk_hit1_cause: assert property (
    monitor1_irq |-> $past(norm_store) || $past(prio_store))
    else $error("monitor one pulse without store");
endmodule
bind adr_regs adr_regs_chk #(.RES_W(RES_W), .NORM_CNT(NORM_CNT)) adr_regs_chk_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .norm_store(norm_store), .prio_store(prio_store), .monitor0_irq(monitor0_irq),
  .monitor1_irq(monitor1_irq), .irq(irq));
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
  import adr_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, norm_store, prio_store, stv, iqv, o;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  norm_index;
  logic [9:0]  norm_value, prio_value, v;
  logic [1:0]  stat;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, m0, m1, irq;
  logic [31:0] rq[$];
  logic [1:0]  hq[$];
  logic        iq[$];
  int          n_mismatch, checks, seed, t, k;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  adr_regs adr_regs_i (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .norm_store(norm_store), .norm_index(norm_index),
    .norm_value(norm_value), .prio_store(prio_store), .prio_value(prio_value),
    .monitor0_irq(m0), .monitor1_irq(m1), .irq(irq));

  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_irq(input logic [1:0] g, input logic [1:0] e);
    cmp_rd({30'h0, g}, {30'h0, e});
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      test_done;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic st(input logic p, input logic [3:0] i, input logic [9:0] d, input logic [1:0] h);
    norm_store <= !p;
    prio_store <= p;
    norm_index <= i;
    norm_value <= d;
    prio_value <= d;
    @(posedge pclk);
    norm_store <= 1'b0;
    prio_store <= 1'b0;
    hq.push_back(h);
    stv <= 1'b1;
    @(posedge pclk);
    stv <= 1'b0;
  endtask
  // Level interrupt noted here, compared by the watcher at the next edge
  task automatic lvl(input logic e);
    iq.push_back(e);
    iqv <= 1'b1;
    @(posedge pclk);
    iqv <= 1'b0;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && !pwrite && rq.size() > 0)
      cmp_rd(prdata, rq.pop_front());
    if (stv && hq.size() > 0)
      cmp_irq({m1, m0}, hq.pop_front());
    if (iqv && iq.size() > 0)
      cmp_irq({1'b0, irq}, {1'b0, iq.pop_front()});
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    test_done;
  end

  initial begin
    seed = 32'h7cf9;
    {presetn, psel, penable, pwrite, norm_store, prio_store, stv, iqv} = 8'h0;
    {paddr, pwdata, norm_index, norm_value, prio_value} = 64'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 20; k++) rd(8'(4 * k), 32'h0);
    for (k = 0; k < 13; k++) begin
      v = 10'($random(seed));
      o = (k % 3 == 0);
      st(k == 12, 4'(k), v, 2'b00);
      if (o) st(k == 12, 4'(k), v, 2'b00);
      rd(8'(4 * k), {16'h0, v, 4'h0, o, 1'b1});
      rd(8'(4 * k), {16'h0, v, 6'h0});
    end
    // Store and clearing read on one edge: the new value keeps its flag
    st(1'b0, 4'h2, 10'h0aa, 2'b00);
    fork
      st(1'b0, 4'h2, 10'h155, 2'b00);
      rd(8'h08, {16'h0, 10'h0aa, 6'h01});
    join
    rd(8'h08, {16'h0, 10'h155, 6'h01});
    rd(8'h08, {16'h0, 10'h155, 6'h00});
    apb(1'b1, ADR_OFS_PRIO, 32'hffff_ffff);
    rd(ADR_OFS_PRIO, {16'h0, v, 6'h0});
    apb(1'b1, ADR_OFS_THR0, 32'hffff_ffff);
    rd(ADR_OFS_THR0, 32'h0000_ffc0);
    apb(1'b1, ADR_OFS_THR0, 32'h0000_4000);
    apb(1'b1, ADR_OFS_THR1, 32'h0000_8000);
    rd(ADR_OFS_THR1, 32'h0000_8000);
    stat = 2'b00;
    for (t = 0; t < 10; t++) begin
      k = (t == 9) ? 15 : t;
      apb(1'b1, ADR_OFS_MON0_CFG, 32'(k * 2 + 33));
      apb(1'b1, ADR_OFS_MON1_CFG, 32'(k * 2 + 1));
      v = (t == 0) ? 10'h100 : (t == 1) ? 10'h200 : 10'($random(seed));
      st(k > 7, 4'(k % 8), v, {v < 10'h200, v > 10'h100});
      stat = stat | {v < 10'h200, v > 10'h100};
      st(1'b0, 4'((k + 1) % 8), v, 2'b00);
    end
    apb(1'b1, ADR_OFS_MON0_CFG, 32'h20);
    apb(1'b1, ADR_OFS_MON1_CFG, 32'h0);
    st(1'b0, 4'h0, 10'h3ff, 2'b00);
    rd(ADR_OFS_IRQ_STAT, {30'h0, stat});
    lvl(1'b0);
    apb(1'b1, ADR_OFS_IRQ_MASK, 32'h3);
    lvl(1'b1);
    apb(1'b1, ADR_OFS_IRQ_STAT, 32'h3);
    rd(ADR_OFS_IRQ_STAT, 32'h0);
    lvl(1'b0);
    test_done;
  end
endmodule
`default_nettype wire
